// ===== hw/bcvd_pkg.sv
// constants and types for the boot configuration vector decoder
// How it works
// - latch vector at cold reset, expose it
// - bits 3:0 pick the PLL factor
// - bus clock is half pipeline clock
// - bit 6 picks little or big endian
// - bit 7 normal reset, 4000-cycle reset output
// - internal source with bit 7 clear waits 18-bit counter expiry
// - bits 10:8 pick the PCI mode
// - PCI enable resets one for satellite modes
// - bit 11 set disables the watchdog
package bcvd_pkg;
    localparam int          VEC_W          = 16;
    localparam int          PLL_LSB        = 0;
    localparam int          PLL_W          = 4;
    localparam int          XDIV_LSB       = 4;
    localparam int          XDIV_W         = 2;
    localparam int          ENDIAN_BIT     = 6;
    localparam int          RMODE_BIT      = 7;
    localparam int          PCI_LSB        = 8;
    localparam int          PCI_W          = 3;
    localparam int          WDOG_BIT       = 11;
    localparam logic [15:0] VEC_RESET      = 16'h0000;
    localparam int          RST_OUT_CYCLES = 4000;
    localparam int          STAB_CNT_W     = 18;
    localparam int          DIV_CNT_W      = 3;

    typedef enum logic [1:0] {
        BCVD_IDLE   = 2'b00,
        BCVD_STAB   = 2'b01,
        BCVD_RSTOUT = 2'b10,
        BCVD_RUN    = 2'b11
    } bcvd_state_t;

    // pll factor in whole multiples; 0 means bypass, 15 reserved
    typedef enum logic [3:0] {
        BCVD_PLL_BYPASS = 4'h0,
        BCVD_PLL_X3     = 4'h3,
        BCVD_PLL_X4     = 4'h4,
        BCVD_PLL_X6     = 4'h6,
        BCVD_PLL_X8     = 4'h8,
        BCVD_PLL_X10    = 4'ha,
        BCVD_PLL_RSVD   = 4'hf
    } bcvd_pll_t;
endpackage

// ===== hw/bcvd_clkdiv.sv
// divider from internal bus clock enable to the external clock output
`timescale 1ns/1ps
module bcvd_clkdiv (
    // clock, reset, enable
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    // control
    input  wire logic                           run,
    input  wire logic [bcvd_pkg::XDIV_W-1:0]    div_code,
    // output
    output logic                                bus_clk,
    output logic                                ext_clk
);
    import bcvd_pkg::*;

    typedef struct packed {
        logic                 bus;
        logic [DIV_CNT_W-1:0] cnt;
        logic                 ext;
    } bcvd_div_t;

    bcvd_div_t s_reg;
    bcvd_div_t s_next;

    always_comb begin
        s_next = s_reg;
        if (run) begin
            s_next.bus = ~s_reg.bus;
            // divide by 1 follows the bus clock; 2 toggles on its rising edges, 4 counts them in cnt
            unique case (div_code)
                2'h0: s_next.ext = ~s_reg.ext;
                2'h1: begin
                    if (!s_reg.bus) s_next.ext = ~s_reg.ext;
                end
                2'h2: begin
                    if (!s_reg.bus) begin
                        s_next.cnt = s_reg.cnt + 3'h1;
                        if (s_reg.cnt[0]) s_next.ext = ~s_reg.ext;
                    end
                end
                // reserved code: output parked low
                2'h3: s_next.ext = 1'b0;
            endcase
        end else begin
            s_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign bus_clk = s_reg.bus;
    assign ext_clk = s_reg.ext;
endmodule

// ===== hw/bcvd_top.sv
// boot configuration vector capture and decode
`timescale 1ns/1ps
module bcvd_top #(
    parameter int RST_OUT_CYCLES = bcvd_pkg::RST_OUT_CYCLES,
    parameter int STAB_CNT_W     = bcvd_pkg::STAB_CNT_W
) (
    // clock, cold reset, enable
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    // vector source
    input  wire logic [bcvd_pkg::VEC_W-1:0]    memory_address_bus,
    input  wire logic                          internal_vec_sel,
    input  wire logic [bcvd_pkg::VEC_W-1:0]    internal_vec,
    // boot vector readback
    output logic [bcvd_pkg::VEC_W-1:0]         boot_vector_register,
    // decoded settings
    output logic [bcvd_pkg::PLL_W-1:0]         pll_factor,
    output logic                               pll_bypass,
    output logic                               pll_reserved,
    output logic [bcvd_pkg::XDIV_W-1:0]        ext_div_code,
    output logic                               big_endian,
    output logic                               reset_mode_reserved,
    output logic [bcvd_pkg::PCI_W-1:0]         pci_mode,
    output logic                               pci_mode_reserved,
    output logic                               pci_en_init,
    output logic                               watchdog_disable,
    // clocks, reset output and done flag
    output logic                               internal_bus_clock,
    output logic                               external_clock_output,
    output logic                               reset_output_pin_n,
    output logic                               config_done
);
    import bcvd_pkg::*;

    localparam int RCNT_W = $clog2(RST_OUT_CYCLES + 1);

    typedef struct packed {
        logic [VEC_W-1:0]      sync1;
        logic [VEC_W-1:0]      sync2;
        logic [VEC_W-1:0]      vec;
        bcvd_state_t           st;
        logic [STAB_CNT_W-1:0] stab;
        logic [RCNT_W-1:0]     rcnt;
        logic                  rst_out_n;
        logic [PLL_W-1:0]      pll;
        logic                  pll_byp;
        logic                  pll_rsv;
        logic                  pci_en;
        logic                  pci_rsv;
    } bcvd_top_t;

    bcvd_top_t s_reg;
    bcvd_top_t s_next;

    function automatic logic [PLL_W-1:0] pll_decode(input logic [PLL_W-1:0] code);
        unique case (code)
            4'h0:    pll_decode = BCVD_PLL_BYPASS;
            4'h1:    pll_decode = BCVD_PLL_X3;
            4'h2:    pll_decode = BCVD_PLL_X4;
            4'h6:    pll_decode = BCVD_PLL_X6;
            4'h7:    pll_decode = BCVD_PLL_X8;
            4'h8:    pll_decode = BCVD_PLL_X10;
            default: pll_decode = BCVD_PLL_RSVD;
        endcase
    endfunction

    // only the two satellite codes come out of reset enabled
    function automatic logic pci_en_decode(input logic [PCI_W-1:0] mode);
        unique case (mode)
            3'h1:    pci_en_decode = 1'b1;
            3'h2:    pci_en_decode = 1'b1;
            default: pci_en_decode = 1'b0;
        endcase
    endfunction

    function automatic logic pci_rsvd_decode(input logic [PCI_W-1:0] mode);
        pci_rsvd_decode = (mode > 3'h5);
    endfunction

    // reserved reset mode skips the wait and keeps the normal reset length
    function automatic logic needs_stab(input logic sel, input logic [VEC_W-1:0] v);
        needs_stab = sel && !v[RMODE_BIT];
    endfunction

    always_comb begin
        s_next = s_reg;
        // pins come from the board: two stages before use
        s_next.sync1 = memory_address_bus;
        s_next.sync2 = s_reg.sync1;
        unique case (s_reg.st)
            BCVD_IDLE: begin
                // first clocked cycle after cold reset release
                s_next.vec = internal_vec_sel ? internal_vec : s_reg.sync2;
                s_next.pll     = pll_decode(s_next.vec[PLL_LSB +: PLL_W]);
                s_next.pll_byp = (s_next.pll == BCVD_PLL_BYPASS);
                s_next.pll_rsv = (s_next.pll == BCVD_PLL_RSVD);
                s_next.pci_en  = pci_en_decode(s_next.vec[PCI_LSB +: PCI_W]);
                s_next.pci_rsv = pci_rsvd_decode(s_next.vec[PCI_LSB +: PCI_W]);
                if (needs_stab(internal_vec_sel, s_next.vec)) begin
                    s_next.st = BCVD_STAB;
                end else begin
                    s_next.st = BCVD_RSTOUT;
                end
                s_next.stab = '0;
                s_next.rcnt = '0;
            end
            BCVD_STAB: begin
                s_next.stab = s_reg.stab + 1'b1;
                if (&s_reg.stab) s_next.st = BCVD_RSTOUT;
            end
            BCVD_RSTOUT: begin
                // held low a full count so the board sees the minimum
                s_next.rcnt = s_reg.rcnt + 1'b1;
                if (s_reg.rcnt == RCNT_W'(RST_OUT_CYCLES - 1)) begin
                    s_next.st        = BCVD_RUN;
                    s_next.rst_out_n = 1'b1;
                end
            end
            BCVD_RUN: begin
                s_next.st = BCVD_RUN;
            end
        endcase
    end

    // only cold reset reaches here; warm resets are outside this block
    always_ff @(posedge clk) begin
        if (rst) begin
            // synchroniser runs through reset so the straps are settled at release
            s_reg.sync1     <= s_next.sync1;
            s_reg.sync2     <= s_next.sync2;
            s_reg.vec       <= VEC_RESET;
            s_reg.st        <= BCVD_IDLE;
            s_reg.stab      <= '0;
            s_reg.rcnt      <= '0;
            s_reg.rst_out_n <= 1'b0;
            s_reg.pll       <= BCVD_PLL_BYPASS;
            s_reg.pll_byp   <= 1'b1;
            s_reg.pll_rsv   <= 1'b0;
            s_reg.pci_en    <= 1'b0;
            s_reg.pci_rsv   <= 1'b0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    bcvd_clkdiv u_div (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .run      (s_reg.st == BCVD_RUN),
        .div_code (s_reg.vec[XDIV_LSB +: XDIV_W]),
        .bus_clk  (internal_bus_clock),
        .ext_clk  (external_clock_output)
    );

    assign boot_vector_register = s_reg.vec;
    assign pll_factor           = s_reg.pll;
    assign pll_bypass           = s_reg.pll_byp;
    assign pll_reserved         = s_reg.pll_rsv;
    assign ext_div_code         = s_reg.vec[XDIV_LSB +: XDIV_W];
    assign big_endian           = s_reg.vec[ENDIAN_BIT];
    assign reset_mode_reserved  = s_reg.vec[RMODE_BIT];
    assign pci_mode             = s_reg.vec[PCI_LSB +: PCI_W];
    assign pci_mode_reserved    = s_reg.pci_rsv;
    assign pci_en_init          = s_reg.pci_en;
    assign watchdog_disable     = s_reg.vec[WDOG_BIT];
    assign reset_output_pin_n   = s_reg.rst_out_n;
    assign config_done          = (s_reg.st == BCVD_RUN);
endmodule

// ===== test/bcvd_chk.sv
// port assertions for the boot vector decoder
`timescale 1ns/1ps
module bcvd_chk #(
    parameter int RST_OUT_CYCLES = 4000
) (
    // clock, reset, enable
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    // observed outputs
    input wire logic [15:0] boot_vector_register,
    input wire logic [1:0]  ext_div_code,
    input wire logic        big_endian,
    input wire logic [2:0]  pci_mode,
    input wire logic        pci_en_init,
    input wire logic        watchdog_disable,
    input wire logic        internal_bus_clock,
    input wire logic        reset_output_pin_n,
    input wire logic        config_done
);
    logic [15:0] bv;
    int          low_cnt;
    assign bv = boot_vector_register;
    // capture edge counts too, so a normal hold ends above the limit
    always_ff @(posedge clk) begin
        if (rst) begin
            low_cnt <= 0;
        end else if (ce && !reset_output_pin_n) begin
            low_cnt <= low_cnt + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_vec_hold: assert property (config_done |-> $stable(bv))
        else $error("boot vector moved");
    chk_div_field: assert property (config_done |-> ext_div_code == bv[5:4])
        else $error("divider code wrong");
    chk_endian_bit: assert property (config_done |-> big_endian == bv[6])
        else $error("endian wrong");
    chk_pci_mode: assert property (config_done |-> pci_mode == bv[10:8])
        else $error("pci mode wrong");
    chk_pci_enable: assert property (config_done |->
        pci_en_init == (!bv[10] && (bv[9] ^ bv[8])))
        else $error("pci enable wrong");
    chk_wdog_bit: assert property (config_done |-> watchdog_disable == bv[11])
        else $error("watchdog wrong");
    chk_bus_half: assert property (config_done |=>
        (internal_bus_clock ^ $past(internal_bus_clock)) == $past(ce))
        else $error("bus clock not half rate");
    chk_reset_len: assert property ($rose(reset_output_pin_n) |-> low_cnt > RST_OUT_CYCLES)
        else $error("reset output too short");
    cover property ($rose(config_done));
    cover property (config_done && pci_en_init);
    cover property (config_done && !ce);
endmodule
bind bcvd_top bcvd_chk #(.RST_OUT_CYCLES(RST_OUT_CYCLES)) u_chk (.*);

// ===== test/bcvd_strap.sv
// board strapping model for the address pins
`timescale 1ns/1ps
module bcvd_strap (
    // strap setting
    input  wire logic [11:0] cfg,
    // pins
    output logic [15:0]      memory_address_bus
);
    assign memory_address_bus = {4'h0, cfg};
endmodule

// ===== test/bcvd_top_bench.sv
// directed bench for the boot vector decoder
`timescale 1ns/1ps
module bcvd_top_bench;
    import bcvd_pkg::*;
    localparam int          RO  = 8;
    localparam int          SW  = 4;
    localparam logic [63:0] PLL = 64'hffff_fffa_86ff_f430;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        sel = 1'b0;
    logic [15:0] ivec = 16'h0000;
    logic [11:0] cfg = 12'h000;
    logic [15:0] pins, bvr;
    logic [3:0]  pll;
    logic [2:0]  pm;
    logic [1:0]  xd;
    logic        byp, prs, en, rmr, pmr, pen, wd, ibc, xck, rpn, done;
    int          failures = 0;
    int          samples_checked = 0;
    bit          timed_out = 1'b0;
    always #20 clk = ~clk;
    bcvd_strap i_strap (.cfg(cfg), .memory_address_bus(pins));
    bcvd_top #(.RST_OUT_CYCLES(RO), .STAB_CNT_W(SW)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .memory_address_bus(pins), .internal_vec_sel(sel),
        .internal_vec(ivec), .boot_vector_register(bvr), .pll_factor(pll), .pll_bypass(byp),
        .pll_reserved(prs), .ext_div_code(xd), .big_endian(en), .reset_mode_reserved(rmr),
        .pci_mode(pm), .pci_mode_reserved(pmr), .pci_en_init(pen), .watchdog_disable(wd),
        .internal_bus_clock(ibc), .external_clock_output(xck), .reset_output_pin_n(rpn),
        .config_done(done));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // cold boot with one strap pattern; cases 5 and 6 boot from the internal source
    task automatic run(input int i);
        logic [11:0] v;
        logic [3:0]  pe;
        logic [9:0]  f;
        logic        b, e, src;
        int          n, nb, ne, hold;
        v = {i[0], i[2:0], i[1], i[2], i[1:0], i[3:0]};
        src = (i == 5) || (i == 6);
        pe = PLL[4 * v[3:0] +: 4];
        f = {!v[10] && (v[9] ^ v[8]), v[10:9] == 2'b11, v[11:4]};
        // stabilisation wait only for the internal source in normal reset mode
        hold = RO + 2 + ((src && !v[7]) ? (1 << SW) : 0);
        @(posedge clk);
        sel <= src;
        ivec <= {4'h0, v};
        cfg <= src ? ~v : v;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
            if (n == 1) begin
                check("reset out low", rpn, 16'h0000);
            end
        end
        if (n >= 200) begin
            failures++;
            timed_out = 1'b1;
            return;
        end
        check("vector", bvr, {4'h0, v});
        check("pll", {prs, byp, pll}, {pe == 4'hf, pe == 4'h0, pe});
        check("fields", {pen, pmr, wd, pm, rmr, en, xd}, f);
        check("hold", 16'(n), 16'(hold));
        check("reset out high", rpn, 16'h0001);
        // straps flip after capture; the vector must ignore them
        @(posedge clk);
        cfg <= ~cfg;
        @(negedge clk);
        nb = 0;
        ne = 0;
        repeat (32) begin
            b = ibc;
            e = xck;
            @(negedge clk);
            nb += int'(ibc != b);
            ne += int'(xck != e);
        end
        check("bus clock", 16'(nb), 16'd32);
        check("ext clock", 16'(ne), 16'((v[5:4] == 2'h3) ? 0 : 32 >> v[5:4]));
        check("held", bvr, {4'h0, v});
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        b = ibc;
        repeat (3) @(negedge clk);
        check("freeze", ibc, b);
        @(posedge clk);
        ce <= 1'b1;
        $display("test %0d done", i);
    endtask
    initial begin
        for (int i = 0; i < 16; i++) begin
            if (!timed_out) begin
                run(i);
            end
        end
        results();
    end
endmodule
